// *** bidir_io_port_rmw_test.sv ***
/*
  Random and directed test of the port block with a reference model.
  Assumes the block and the outside model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bioprt_params.svh"

module bidir_io_port_rmw_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  bioprt_pkg::bioprt_req_s req = '{bioprt_pkg::BIOPRT_OP_NONE, 2'h0, 3'h0, 8'h00};
  logic [2:0] t_op = 3'h0;
  logic [23:0] ext = 24'h000000;
  logic [23:0] pins;
  wire logic [23:0] outs;
  wire logic [23:0] oes;
  bioprt_pkg::bioprt_rd_s rd;
  logic cyc_end;
  logic cyc_clk;
  logic [7:0] lat [3];
  logic [7:0] trs [3];
  logic [7:0] ck [8];
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  bioprt_pkg::bioprt_op_e ops [5] = '{bioprt_pkg::BIOPRT_OP_NONE, bioprt_pkg::BIOPRT_OP_WRITE,
    bioprt_pkg::BIOPRT_OP_BSET, bioprt_pkg::BIOPRT_OP_BCLR, bioprt_pkg::BIOPRT_OP_TSLOAD};

  bioprt_top i_bioprt_top (.clk_i(clk), .master_clear_n_i(rst_n), .req_i(req), .tsl_operand_i(t_op),
    .pin_first_i(pins[7:0]), .pin_second_i(pins[15:8]), .pin_third_i(pins[23:16]),
    .pin_first_o(outs[7:0]), .pin_second_o(outs[15:8]), .pin_third_o(outs[23:16]),
    .pin_first_oe_o(oes[7:0]), .pin_second_oe_o(oes[15:8]), .pin_third_oe_o(oes[23:16]),
    .rd_o(rd), .cycle_end_o(cyc_end), .instr_cycle_clock_out_o(cyc_clk));

  bioprt_ext_model i_bioprt_ext_model (.out_i(outs), .oe_i(oes), .ext_i(ext), .pin_o(pins));

  always #2 clk = ~clk;

  // ****************************************
  // Reference model and checks
  // ****************************************
  function automatic logic [7:0] pin_exp(input int k);
    return (lat[k] & ~trs[k]) | (ext[k*8 +: 8] & trs[k]);
  endfunction

  task automatic model_reset();
    for (int k = 0; k < 3; k++)
    begin
      lat[k] = 8'h00;
      trs[k] = 8'hff;
    end
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_all(input logic [23:0] pv, input bit do_rd);
    for (int k = 0; k < 3; k++)
    begin
      check(outs[k*8 +: 8], lat[k]);
      check(oes[k*8 +: 8], ~trs[k]);
      if (do_rd)
        check(rd[(2-k)*8 +: 8], pv[k*8 +: 8]);
    end
  endtask

  task automatic do_op(input bioprt_pkg::bioprt_op_e op, input logic [1:0] p, input logic [2:0] b,
    input logic [7:0] d, input logic [2:0] t, input logic [23:0] nx, input bit chk);
    logic [23:0] pv;
    int n;
    int k;
    pv = {pin_exp(2), pin_exp(1), pin_exp(0)};
    k = int'(p);
    n = 0;
    @(posedge clk);
    req <= '{op, p, b, d};
    t_op <= t;
    ext <= nx;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (cyc_end !== 1'b1 && n < 8);
    check(8'(n), 8'(`BIOPRT_PHASES));
    if (k < 3 && op == bioprt_pkg::BIOPRT_OP_WRITE)
      lat[k] = d;
    if (k < 3 && (op == bioprt_pkg::BIOPRT_OP_BSET || op == bioprt_pkg::BIOPRT_OP_BCLR))
    begin
      lat[k] = pv[k*8 +: 8];
      lat[k][b] = (op == bioprt_pkg::BIOPRT_OP_BSET);
    end
    if (op == bioprt_pkg::BIOPRT_OP_TSLOAD && t >= 3'h5)
      trs[int'(t) - 5] = d;
    check_all(pv, chk);
  endtask

  task automatic rand_ops(input int cnt);
    for (int i = 0; i < cnt; i++)
      do_op(ops[$urandom % 5], 2'($urandom % 4), 3'($urandom), 8'($urandom), 3'($urandom), 24'($urandom), 1);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fail_count++;
      complete_run();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'h6afb1df5));
    model_reset();
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check_all(24'h0, 1);
    do_op(bioprt_pkg::BIOPRT_OP_NONE, 2'h3, 3'h0, 8'h00, 3'h0, 24'h00c000, 0);
    $display("test reset done");
    do_op(bioprt_pkg::BIOPRT_OP_TSLOAD, 2'h3, 3'h0, 8'hf0, 3'h6, 24'h00c000, 1);
    do_op(bioprt_pkg::BIOPRT_OP_WRITE, 2'h1, 3'h0, 8'h0f, 3'h0, 24'h00c000, 1);
    do_op(bioprt_pkg::BIOPRT_OP_BCLR, 2'h1, 3'h7, 8'h00, 3'h0, 24'h00c000, 1);
    do_op(bioprt_pkg::BIOPRT_OP_BCLR, 2'h1, 3'h6, 8'h00, 3'h0, 24'h00c000, 1);
    do_op(bioprt_pkg::BIOPRT_OP_TSLOAD, 2'h3, 3'h0, 8'h3f, 3'h6, 24'h00c000, 1);
    do_op(bioprt_pkg::BIOPRT_OP_WRITE, 2'h3, 3'h0, 8'haa, 3'h0, 24'h00c000, 1);
    $display("test read modify write done");
    for (int t = 0; t < 8; t++)
      do_op(bioprt_pkg::BIOPRT_OP_TSLOAD, 2'h3, 3'h0, 8'($urandom), 3'(t), 24'($urandom), 1);
    $display("test operands done");
    rand_ops(200);
    $display("test random done");
    do_op(bioprt_pkg::BIOPRT_OP_NONE, 2'h3, 3'h0, 8'h00, 3'h0, ext, 1);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk);
      ck[i] = {7'h00, cyc_clk};
    end
    for (int i = 0; i < 4; i++)
    begin
      check(ck[i], ck[i+4]);
      check(ck[i], ~ck[(i+2) % 8] & 8'h01);
    end
    $display("test cycle clock done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    model_reset();
    check_all(24'h0, 1);
    @(posedge clk);
    rst_n <= 1'b1;
    do_op(bioprt_pkg::BIOPRT_OP_NONE, 2'h3, 3'h0, 8'h00, 3'h0, 24'h5a5a5a, 0);
    rand_ops(30);
    $display("test second reset done");
    complete_run();
  end
endmodule

`default_nettype wire

// *** bioprt_cyc.sv ***
/*
  Instruction cycle phase counter and cycle clock output.
  Assumes clk_i is the oscillator input clock, one phase per rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bioprt_params.svh"

module bioprt_cyc
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic [1:0] phase_o,
  output logic cyc_clk_o
);

  typedef struct packed {
    logic [1:0] phase;
    logic clk;
  } bioprt_cyc_s;

  bioprt_cyc_s st_r;
  bioprt_cyc_s st_nxt;

  // ****************************************
  // Phase count
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.phase = st_r.phase + 2'h1;
    // RL8 - quarter rate clock
    st_nxt.clk = (st_nxt.phase < `BIOPRT_PHASE_HALF);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      // Phase zero opens high
      st_r <= '{phase: 2'h0, clk: 1'b1};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign phase_o = st_r.phase;
  assign cyc_clk_o = st_r.clk;

  // RL8 - clock period four
  cyc_period_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(cyc_clk_o) |-> ##4 $rose(cyc_clk_o)) // RL8
    else $error("cycle clock not quarter rate");

endmodule

`default_nettype wire

// *** bioprt_ext_model.sv ***
/*
  Model of the outside circuitry on the three ports.
  Assumes the bench sets the levels that the outside drives.
*/
`timescale 1ns/10ps
`default_nettype none

module bioprt_ext_model
(
  input wire logic [23:0] out_i,
  input wire logic [23:0] oe_i,
  input wire logic [23:0] ext_i,
  output logic [23:0] pin_o
);
  // ****************************************
  // Pin resolution
  // ****************************************
  // Driven bits follow the port, released bits the outside
  assign pin_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule

`default_nettype wire

// *** bioprt_params.svh ***
/*
  Constants of the bidirectional port block: widths, port selects, reset values,
  phase counts of the instruction cycle.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef BIOPRT_PARAMS_SVH
`define BIOPRT_PARAMS_SVH

// ****************************************
// Port geometry
// ****************************************
`define BIOPRT_WIDTH 8
`define BIOPRT_NPORTS 3
`define BIOPRT_TSL_OP_FIRST 3'h5
`define BIOPRT_TSL_OP_SECOND 3'h6
`define BIOPRT_TSL_OP_THIRD 3'h7

// ****************************************
// Reset values
// ****************************************
`define BIOPRT_TSL_RESET 8'hff
`define BIOPRT_LATCH_RESET 8'h00

// ****************************************
// Instruction cycle timing
// ****************************************
`define BIOPRT_PHASES 4
`define BIOPRT_PHASE_LAST 2'h3
`define BIOPRT_PHASE_HALF 2'h2

`endif

// *** bioprt_pkg.sv ***
/*
  Types of the bidirectional port block.
  Assumes bioprt_params.svh is on the include path.
*/
`include "bioprt_params.svh"

package bioprt_pkg;

  typedef enum logic [4:0] {
    BIOPRT_OP_NONE = 5'h01,
    BIOPRT_OP_WRITE = 5'h02,
    BIOPRT_OP_BSET = 5'h04,
    BIOPRT_OP_BCLR = 5'h08,
    BIOPRT_OP_TSLOAD = 5'h10
  } bioprt_op_e;

  typedef struct packed {
    bioprt_op_e op;
    logic [1:0] port;
    logic [2:0] bit_idx;
    logic [7:0] wdata;
  } bioprt_req_s;

  typedef struct packed {
    logic [7:0] rd_first;
    logic [7:0] rd_second;
    logic [7:0] rd_third;
  } bioprt_rd_s;

endpackage

// *** bioprt_top.sv ***
/*
  Three eight-bit bidirectional ports with data latches, tristate latches and
  pin reads, driven by a CPU-side request once per instruction cycle.
  Assumes requests are held stable through the instruction cycle and taken at
  its last phase; pins are resolved outside from out and enable.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bioprt_params.svh"

// Function
// RL1 - Bit set/clear read pins, write all
// RL2 - Input pins latch sensed level on RMW
// RL3 - Input ignores latch; output drives latch
// RL4 - Port read returns pin levels
// RL5 - Latches update at cycle end
// RL6 - Pins sampled at cycle start
// RL7 - Software separates write and read
// RL8 - Quarter rate cycle clock output
// RL9 - Active low master clear resets
// RL10 - Tristate one disables, zero drives
// RL11 - Tristate load 5,6,7 selects port
// RL12 - Reset sets all tristate bits
module bioprt_top
#(
  parameter int WIDTH = `BIOPRT_WIDTH
)
(
  input wire logic clk_i,
  input wire logic master_clear_n_i,
  input wire bioprt_pkg::bioprt_req_s req_i,
  input wire logic [2:0] tsl_operand_i,
  input wire logic [WIDTH-1:0] pin_first_i,
  input wire logic [WIDTH-1:0] pin_second_i,
  input wire logic [WIDTH-1:0] pin_third_i,
  output logic [WIDTH-1:0] pin_first_o,
  output logic [WIDTH-1:0] pin_second_o,
  output logic [WIDTH-1:0] pin_third_o,
  output logic [WIDTH-1:0] pin_first_oe_o,
  output logic [WIDTH-1:0] pin_second_oe_o,
  output logic [WIDTH-1:0] pin_third_oe_o,
  output var bioprt_pkg::bioprt_rd_s rd_o,
  output logic cycle_end_o,
  output logic instr_cycle_clock_out_o
);

  typedef struct packed {
    logic [2:0][WIDTH-1:0] latch;
    logic [2:0][WIDTH-1:0] tsl;
    logic [2:0][WIDTH-1:0] sample;
    logic [2:0][WIDTH-1:0] pout;
    logic [2:0][WIDTH-1:0] poe;
    logic [2:0][WIDTH-1:0] rd;
    logic cend;
    logic cclk;
  } bioprt_st_s;

  bioprt_st_s st_r;
  bioprt_st_s st_nxt;
  logic [1:0] phase;
  logic cyc_clk;
  logic rst_n;
  logic [2:0][WIDTH-1:0] pins;

  // RL9 - active low clear
  assign rst_n = master_clear_n_i;
  assign pins[0] = pin_first_i;
  assign pins[1] = pin_second_i;
  assign pins[2] = pin_third_i;

  // ****************************************
  // Cycle timing
  // ****************************************
  bioprt_cyc u_cyc
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .phase_o(phase),
    .cyc_clk_o(cyc_clk)
  );

  function automatic logic [1:0] tsl_port(input logic [2:0] opnd);
    case (opnd)
      `BIOPRT_TSL_OP_FIRST: tsl_port = 2'h0;
      `BIOPRT_TSL_OP_SECOND: tsl_port = 2'h1;
      `BIOPRT_TSL_OP_THIRD: tsl_port = 2'h2;
      default: tsl_port = 2'h3;
    endcase
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [WIDTH-1:0] rmw;
    logic [1:0] p;
    rmw = '0;
    p = req_i.port;
    st_nxt = st_r;
    st_nxt.cend = (phase == `BIOPRT_PHASE_LAST);
    st_nxt.cclk = cyc_clk;
    // RL6 - sample at start
    if (phase == 2'h0)
    begin
      st_nxt.sample = pins;
    end
    // RL5 - write at end
    if (phase == `BIOPRT_PHASE_LAST && p < 2'h3)
    begin
      // RL1 - read pins, modify
      rmw = st_r.sample[p];
      case (req_i.op)
        bioprt_pkg::BIOPRT_OP_WRITE:
        begin
          st_nxt.latch[p] = req_i.wdata;
        end
        bioprt_pkg::BIOPRT_OP_BSET:
        begin
          rmw[req_i.bit_idx] = 1'b1;
          // RL2 - inputs relatch pins
          st_nxt.latch[p] = rmw;
        end
        bioprt_pkg::BIOPRT_OP_BCLR:
        begin
          rmw[req_i.bit_idx] = 1'b0;
          st_nxt.latch[p] = rmw;
        end
        default:
        begin
          st_nxt.latch[p] = st_r.latch[p];
        end
      endcase
    end
    // RL11 - tristate load select
    if (phase == `BIOPRT_PHASE_LAST && req_i.op == bioprt_pkg::BIOPRT_OP_TSLOAD &&
        tsl_port(tsl_operand_i) != 2'h3)
    begin
      st_nxt.tsl[tsl_port(tsl_operand_i)] = req_i.wdata;
    end
    for (int i = 0; i < 3; i++)
    begin
      // RL10 - one disables driver
      st_nxt.poe[i] = ~st_nxt.tsl[i];
      // RL3 - drive latch value
      st_nxt.pout[i] = st_nxt.latch[i];
      // RL4 - reads return pins
      st_nxt.rd[i] = st_nxt.sample[i];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      // RL12 - all pins input
      for (int i = 0; i < 3; i++)
      begin
        st_r.tsl[i] <= WIDTH'(`BIOPRT_TSL_RESET);
        st_r.latch[i] <= WIDTH'(`BIOPRT_LATCH_RESET);
      end
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pin_first_o = st_r.pout[0];
  assign pin_second_o = st_r.pout[1];
  assign pin_third_o = st_r.pout[2];
  assign pin_first_oe_o = st_r.poe[0];
  assign pin_second_oe_o = st_r.poe[1];
  assign pin_third_oe_o = st_r.poe[2];
  assign rd_o = '{st_r.rd[0], st_r.rd[1], st_r.rd[2]};
  assign cycle_end_o = st_r.cend;
  assign instr_cycle_clock_out_o = st_r.cclk;

  // ****************************************
  // Checks
  // ****************************************
  rmw_latch_pins_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL1
    (phase == 2'h3 && req_i.op == bioprt_pkg::BIOPRT_OP_BSET && req_i.port == 2'h1)
    |=> (st_r.latch[1] == ($past(st_r.sample[1]) | (8'h01 << $past(req_i.bit_idx)))))
    else $error("bit set latch wrong");
  rmw_clr_pins_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL2
    (phase == 2'h3 && req_i.op == bioprt_pkg::BIOPRT_OP_BCLR && req_i.port == 2'h0)
    |=> (st_r.latch[0] == ($past(st_r.sample[0]) & ~(8'h01 << $past(req_i.bit_idx)))))
    else $error("bit clear latch wrong");
  drive_latch_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL3
    ##1 (pin_second_o == $past(st_nxt.latch[1])))
    else $error("driven value not latch");
  read_pins_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL4
    (phase == 2'h0) |=> (rd_o.rd_first == $past(pin_first_i)))
    else $error("read not pin level");
  write_end_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL5
    (phase != 2'h3) |=> (st_r.latch == $past(st_r.latch)))
    else $error("latch changed mid cycle");
  sample_start_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL6
    (phase != 2'h0) |=> (st_r.sample == $past(st_r.sample)))
    else $error("sample changed mid cycle");
  cyc_out_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL8
    $rose(instr_cycle_clock_out_o) |-> ##4 $rose(instr_cycle_clock_out_o))
    else $error("cycle clock out not quarter rate");
  reset_tsl_a: assert property (@(posedge clk_i) // RL12
    !rst_n |=> (pin_first_oe_o == 8'h00 && pin_third_oe_o == 8'h00))
    else $error("reset left driver on");
  tsl_oe_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL10
    ##1 (pin_third_oe_o == ~$past(st_nxt.tsl[2])))
    else $error("enable not inverse tristate");
  tsl_load_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RL11
    (phase == 2'h3 && req_i.op == bioprt_pkg::BIOPRT_OP_TSLOAD && tsl_operand_i == 3'h6)
    |=> (st_r.tsl[1] == $past(req_i.wdata)))
    else $error("tristate load wrong port");
  rst_clear_a: assert property (@(posedge clk_i) // RL9
    !master_clear_n_i |=> (st_r.tsl[1] == 8'hff))
    else $error("clear did not reset");

  bset_seen_c: cover property (@(posedge clk_i) phase == 2'h3 && req_i.op == bioprt_pkg::BIOPRT_OP_BSET);
  tsl_seen_c: cover property (@(posedge clk_i) phase == 2'h3 && req_i.op == bioprt_pkg::BIOPRT_OP_TSLOAD);
  drive_seen_c: cover property (@(posedge clk_i) pin_second_oe_o != 8'h00);

endmodule

`default_nettype wire
